// file: logic/urx_top.sv
/*
 * urx_top: uart receiver with fifo, receive timeout and error interrupts,
 * and the full register map as an avalon-mm slave.
 * assumes rx_in is asynchronous to core_clk_in and that an outside
 * transmitter takes characters from tx_push_out.
 */
`timescale 1ns/1ps
module urx_top
	import urx_pkg::*;
(
	input wire logic core_clk_in, // 250 MHz core clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic [6:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall
	input wire logic rx_in, // serial receive pin
	output logic [7:0] tx_data_out, // character to transmit
	output logic tx_push_out, // one-cycle transmit push
	output logic irq_out // shared interrupt
);
	// ************************************************************
	// bus slave
	// ************************************************************
	logic busy_q; // second cycle of an access
	logic req; // any request
	logic acc; // completing edge
	logic cap; // read capture edge
	logic [4:0] widx; // word index
	logic [31:0] rdmux; // read value
	assign req = avs_read_in | avs_write_in;
	assign acc = req & busy_q;
	assign cap = avs_read_in & ~busy_q;
	assign widx = avs_address_in[6:2];
	// one wait state: low in the second cycle of every access
	assign avs_waitrequest_out = req & ~busy_q;

	// wait-state toggle
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			busy_q <= 1'b0;
		else
			busy_q <= req & ~busy_q;
	end

	// decoded write strobes, only on the completing edge
	function automatic logic hit(input logic [4:0] w, input logic [6:0] off);
		hit = (w == off[6:2]);
	endfunction
	logic wr_data, wr_err, wr_iclr; // side-effect writes
	assign wr_data = acc & avs_write_in & hit(widx, OFF_DATA);
	assign wr_err = acc & avs_write_in & hit(widx, OFF_ERR);
	assign wr_iclr = acc & avs_write_in & hit(widx, OFF_ICLR);

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [21:0] idle_period; // receive idle period
	logic [7:0] rx_lc; // receive line control
	logic [15:0] baud_divisor_integer; // integer divisor
	logic [5:0] baud_divisor_fraction; // fractional divisor, stored only
	logic [7:0] tx_lc; // transmit line control, stored only
	logic [31:0] ctrl; // main control
	logic [31:0] fifo_level_select; // level select, stored only
	logic [10:0] imask; // interrupt mask
	logic [2:0] dmac; // dma control, stored only
	logic [6:0] swfc; // soft flow control, stored only
	logic [7:0] fc_char [4]; // resume 1, resume 2, pause 1, pause 2

	// plain read-write storage
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			idle_period <= IDLE_RST;
			rx_lc <= 8'h00;
			baud_divisor_integer <= 16'h0000;
			baud_divisor_fraction <= 6'h00;
			tx_lc <= 8'h00;
			ctrl <= CTRL_RST;
			fifo_level_select <= FIFO_LEVEL_SELECT_RST;
			imask <= 11'h000;
			dmac <= 3'h0;
			swfc <= 7'h00;
			for (int i = 0; i < 4; i++)
				fc_char[i] <= 8'h00;
		end
		else if (acc && avs_write_in)
		begin
			case (1'b1)
				hit(widx, OFF_IDLE): idle_period <= avs_writedata_in[21:0];
				hit(widx, OFF_RXLC): rx_lc <= avs_writedata_in[7:0];
				hit(widx, OFF_BAUD_DIVISOR_INTEGER): baud_divisor_integer <= avs_writedata_in[15:0];
				hit(widx, OFF_BAUD_DIVISOR_FRACTION): baud_divisor_fraction <= avs_writedata_in[5:0];
				hit(widx, OFF_TXLC): tx_lc <= avs_writedata_in[7:0];
				hit(widx, OFF_CTRL): ctrl <= avs_writedata_in;
				hit(widx, OFF_FIFO_LEVEL_SELECT): fifo_level_select <= avs_writedata_in;
				hit(widx, OFF_IMSK): imask <= avs_writedata_in[10:0];
				hit(widx, OFF_DMA): dmac <= avs_writedata_in[2:0];
				hit(widx, OFF_SWFC): swfc <= avs_writedata_in[6:0];
				hit(widx, OFF_RES1): fc_char[0] <= avs_writedata_in[7:0];
				hit(widx, OFF_RES2): fc_char[1] <= avs_writedata_in[7:0];
				hit(widx, OFF_PAU1): fc_char[2] <= avs_writedata_in[7:0];
				hit(widx, OFF_PAU2): fc_char[3] <= avs_writedata_in[7:0];
				default: ; // unmapped or side-effect only
			endcase
		end
	end

	// transmit queue hand-off
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tx_data_out <= 8'h00;
			tx_push_out <= 1'b0;
		end
		else
		begin
			tx_push_out <= wr_data;
			if (wr_data)
				tx_data_out <= avs_writedata_in[7:0];
		end
	end

	// ************************************************************
	// sampling tick and pin synchroniser
	// ************************************************************
	logic rx_m, rx_s; // two-flop synchroniser
	logic [15:0] div_cnt; // divisor counter
	logic tick; // 16x oversampling enable
	logic rx_en; // receiver running
	assign rx_en = ctrl[CTRL_EN] & ctrl[CTRL_RXE];
	// a zero divisor would stall the receiver, so it acts as one
	assign tick = (div_cnt + 16'h0001 >= ((baud_divisor_integer == 16'h0000) ? 16'h0001 : baud_divisor_integer));

	// pin synchroniser, reset to line idle
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_m <= 1'b1;
			rx_s <= 1'b1;
		end
		else
		begin
			rx_m <= rx_in;
			rx_s <= rx_m;
		end
	end

	// divisor counter; the fractional part is not applied
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			div_cnt <= 16'h0000;
		else if (tick)
			div_cnt <= 16'h0000;
		else
			div_cnt <= div_cnt + 16'h0001;
	end

	// ************************************************************
	// receive state machine
	// ************************************************************
	urx_state_t rx_st; // receiver state
	logic [3:0] samp; // ticks within a bit
	logic [2:0] bit_n; // data bit index
	logic [7:0] shreg; // receive shift register
	logic par_bit; // received parity bit
	logic rx_done; // character complete, one cycle
	logic [10:0] rx_word; // {break, parity, framing, data}
	logic [2:0] last_bit; // index of last data bit
	logic par_bad; // parity mismatch
	logic is_fe, is_brk; // stop bit checks
	assign last_bit = 3'h4 + {1'b0, rx_lc[LC_WLEN+1:LC_WLEN]};
	// parity per enable, even and stick bits
	assign par_bad = rx_lc[LC_PEN] & ((rx_lc[LC_SPS] ? par_bit : (^shreg ^ par_bit))
		!= ~rx_lc[LC_EPS]);
	assign is_fe = ~rx_s;
	// whole word low is a break
	assign is_brk = ~rx_s & (shreg == 8'h00) & ~(rx_lc[LC_PEN] & par_bit);

	// serial framing, bits sampled mid-bit at 16x
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_st <= RX_IDLE;
			samp <= 4'h0;
			bit_n <= 3'h0;
			shreg <= 8'h00;
			par_bit <= 1'b0;
			rx_done <= 1'b0;
			rx_word <= 11'h000;
		end
		else
		begin
			rx_done <= 1'b0;
			if (tick)
				samp <= samp + 4'h1;
			case (rx_st)
				RX_IDLE:
				begin
					samp <= 4'h0;
					if (tick && rx_en && !rx_s)
						rx_st <= RX_START;
				end
				RX_START:
					if (tick && samp == OVSP_MID)
					begin
						samp <= 4'h0;
						bit_n <= 3'h0;
						shreg <= 8'h00;
						par_bit <= 1'b0;
						rx_st <= rx_s ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (tick && samp == OVSP_LAST)
					begin
						shreg[bit_n] <= rx_s;
						bit_n <= bit_n + 3'h1;
						if (bit_n == last_bit)
							rx_st <= rx_lc[LC_PEN] ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (tick && samp == OVSP_LAST)
					begin
						par_bit <= rx_s;
						rx_st <= RX_STOP;
					end
				RX_STOP:
					if (tick && samp == OVSP_LAST)
					begin
						rx_done <= 1'b1;
						if (is_brk)
						begin
							rx_word <= {1'b1, 2'b00, 8'h00};
							rx_st <= RX_BRK;
						end
						else
						begin
							rx_word <= {1'b0, par_bad, is_fe, shreg};
							rx_st <= RX_IDLE;
						end
					end
				RX_BRK:
					if (rx_s)
						rx_st <= RX_IDLE;
				default:
					rx_st <= RX_IDLE;
			endcase
		end
	end

	// ************************************************************
	// receive fifo
	// ************************************************************
	logic [10:0] fifo_mem [FIFO_DEPTH]; // characters with flags
	logic [FIFO_AW-1:0] wr_ptr, rd_ptr; // pointers
	logic [FIFO_AW:0] fill; // entries held
	logic [FIFO_AW:0] lim; // depth in use
	logic empty, full, push, pop, ovr; // fifo events
	logic oe_data; // data port overrun bit
	assign lim = rx_lc[LC_FEN] ? (FIFO_AW+1)'(FIFO_DEPTH) : (FIFO_AW+1)'(1);
	assign empty = (fill == '0);
	assign full = (fill >= lim);
	// a full fifo is never written
	assign push = rx_done & ~full;
	assign ovr = rx_done & full;
	assign pop = cap & hit(widx, OFF_DATA) & ~empty;

	always_ff @(posedge core_clk_in)
	begin
		if (push)
			fifo_mem[wr_ptr] <= rx_word;
	end

	// pointers and fill level
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			fill <= fill + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
		end
	end

	// overrun bit of the data port
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			oe_data <= 1'b0;
		// set on overrun, cleared by next store
		else if (ovr)
			oe_data <= 1'b1;
		else if (push)
			oe_data <= 1'b0;
	end

	// ************************************************************
	// error status and interrupts
	// ************************************************************
	logic [3:0] err_stat; // overrun, break, parity, framing
	logic [10:0] raw; // raw interrupt status
	logic [10:0] masked; // masked interrupt status
	logic [21:0] idle_cnt; // idle ticks while data waits
	logic rt_hit; // idle period reached
	// period counts 16x ticks of the divisor
	assign rt_hit = tick & ~empty & (idle_period != 22'h000000)
		& (idle_cnt + 22'h000001 >= idle_period);

	// error status: head flags caught on a data read, overrun sticky
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			err_stat <= 4'h0;
		else
		begin
			if (wr_err)
				err_stat <= 4'h0;
			if (pop)
				err_stat[2:0] <= {fifo_mem[rd_ptr][10:8]};
			// overrun set wins over a clear in the same cycle
			if (ovr)
				err_stat[3] <= 1'b1;
		end
	end

	// idle counter: restarts on every stored character
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			idle_cnt <= 22'h000000;
		else if (push || empty || raw[IRQ_RT])
			idle_cnt <= 22'h000000;
		else if (tick)
			idle_cnt <= idle_cnt + 22'h000001;
	end

	// raw status: events set, clears per written bit
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			raw <= 11'h000;
		else
		begin
			if (wr_iclr)
				raw <= raw & ~(avs_writedata_in[10:0] & IRQ_IMPL);
			if (empty && !push)
				raw[IRQ_RT] <= 1'b0;
			if (rt_hit)
				raw[IRQ_RT] <= 1'b1;
			if (rx_done && rx_word[8])
				raw[IRQ_FE] <= 1'b1;
			if (rx_done && rx_word[9])
				raw[IRQ_PE] <= 1'b1;
			if (rx_done && rx_word[10])
				raw[IRQ_BE] <= 1'b1;
			if (ovr)
				raw[IRQ_OE] <= 1'b1;
		end
	end

	assign masked = raw & imask;
	assign irq_out = |masked;

	// ************************************************************
	// read data
	// ************************************************************
	logic [31:0] flags; // flag status view
	always_comb
	begin
		flags = FLAG_RST;
		flags[FLAG_RXFE] = empty;
		flags[FLAG_RXFF] = full;
	end

	// read multiplexer; unmapped and write-only words read zero
	always_comb
	begin
		rdmux = 32'h00000000;
		case (1'b1)
			hit(widx, OFF_DATA): rdmux = {20'h00000, oe_data, empty ? 11'h000 : fifo_mem[rd_ptr]};
			hit(widx, OFF_ERR): rdmux = {28'h0000000, err_stat};
			hit(widx, OFF_IDLE): rdmux = {10'h000, idle_period};
			hit(widx, OFF_FLAG): rdmux = flags;
			hit(widx, OFF_RXLC): rdmux = {24'h000000, rx_lc};
			hit(widx, OFF_BAUD_DIVISOR_INTEGER): rdmux = {16'h0000, baud_divisor_integer};
			hit(widx, OFF_BAUD_DIVISOR_FRACTION): rdmux = {26'h0000000, baud_divisor_fraction};
			hit(widx, OFF_TXLC): rdmux = {24'h000000, tx_lc};
			hit(widx, OFF_CTRL): rdmux = ctrl;
			hit(widx, OFF_FIFO_LEVEL_SELECT): rdmux = fifo_level_select;
			hit(widx, OFF_IMSK): rdmux = {21'h000000, imask};
			hit(widx, OFF_RAW): rdmux = {21'h000000, raw};
			hit(widx, OFF_MSKD): rdmux = {21'h000000, masked};
			hit(widx, OFF_DMA): rdmux = {29'h00000000, dmac};
			hit(widx, OFF_SWFC): rdmux = {25'h0000000, swfc};
			hit(widx, OFF_RES1): rdmux = {24'h000000, fc_char[0]};
			hit(widx, OFF_RES2): rdmux = {24'h000000, fc_char[1]};
			hit(widx, OFF_PAU1): rdmux = {24'h000000, fc_char[2]};
			hit(widx, OFF_PAU2): rdmux = {24'h000000, fc_char[3]};
			default: rdmux = 32'h00000000;
		endcase
	end

	// read data captured in the first cycle, held through the second
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			avs_readdata_out <= 32'h00000000;
		else if (cap)
			avs_readdata_out <= rdmux;
	end
endmodule

// file: logic/urx_pkg.sv
/*
 * urx_pkg: constants shared by the receive, timeout and error interrupt block.
 * assumes a 7-bit byte address on the register bus, one 32-bit word per register.
 */
package urx_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [6:0] OFF_DATA = 7'h00; // data port
	localparam logic [6:0] OFF_ERR = 7'h04; // error status / error clear
	localparam logic [6:0] OFF_IDLE = 7'h0C; // receive idle period
	localparam logic [6:0] OFF_FLAG = 7'h18; // flag status
	localparam logic [6:0] OFF_RXLC = 7'h1C; // receive line control
	localparam logic [6:0] OFF_BAUD_DIVISOR_INTEGER = 7'h24; // integer divisor
	localparam logic [6:0] OFF_BAUD_DIVISOR_FRACTION = 7'h28; // fractional divisor
	localparam logic [6:0] OFF_TXLC = 7'h2C; // transmit line control
	localparam logic [6:0] OFF_CTRL = 7'h30; // main control
	localparam logic [6:0] OFF_FIFO_LEVEL_SELECT = 7'h34; // fifo level select
	localparam logic [6:0] OFF_IMSK = 7'h38; // interrupt mask
	localparam logic [6:0] OFF_RAW = 7'h3C; // raw interrupt status
	localparam logic [6:0] OFF_MSKD = 7'h40; // masked interrupt status
	localparam logic [6:0] OFF_ICLR = 7'h44; // interrupt clear
	localparam logic [6:0] OFF_DMA = 7'h48; // dma control
	localparam logic [6:0] OFF_SWFC = 7'h50; // soft flow control
	localparam logic [6:0] OFF_RES1 = 7'h54; // resume char 1
	localparam logic [6:0] OFF_RES2 = 7'h58; // resume char 2
	localparam logic [6:0] OFF_PAU1 = 7'h5C; // pause char 1
	localparam logic [6:0] OFF_PAU2 = 7'h60; // pause char 2
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [21:0] IDLE_RST = 22'h0001FF; // idle period
	localparam logic [31:0] FLAG_RST = 32'h00001E90; // flag status
	localparam logic [31:0] CTRL_RST = 32'h00040300; // main control
	localparam logic [31:0] FIFO_LEVEL_SELECT_RST = 32'h00000012; // level select
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_EN = 0; // uart enable
	localparam int CTRL_RXE = 9; // receive enable
	localparam int LC_PEN = 1; // parity enable
	localparam int LC_EPS = 2; // even parity select
	localparam int LC_FEN = 4; // fifo enable
	localparam int LC_WLEN = 5; // word length, two bits
	localparam int LC_SPS = 7; // stick parity
	localparam int FLAG_RXFE = 4; // receive fifo empty
	localparam int FLAG_RXFF = 6; // receive fifo full
	localparam int IRQ_RT = 6; // receive timeout
	localparam int IRQ_FE = 7; // framing error
	localparam int IRQ_PE = 8; // parity error
	localparam int IRQ_BE = 9; // break error
	localparam int IRQ_OE = 10; // overrun error
	localparam logic [10:0] IRQ_IMPL = 11'h7C0; // implemented raw bits
	// ************************************************************
	// sizes and timing
	// ************************************************************
	localparam int FIFO_DEPTH = 32; // receive fifo entries
	localparam int FIFO_AW = 5; // fifo pointer width
	localparam logic [3:0] OVSP_MID = 4'h7; // start bit check tick
	localparam logic [3:0] OVSP_LAST = 4'hF; // last tick of a bit
	// receiver states, one-hot
	typedef enum logic [5:0] {
		RX_IDLE = 6'b000001,
		RX_START = 6'b000010,
		RX_DATA = 6'b000100,
		RX_PAR = 6'b001000,
		RX_STOP = 6'b010000,
		RX_BRK = 6'b100000
	} urx_state_t;
endpackage

// file: verification/urx_props.sv
/*
 * urx_props: bus, push, mask and reserved-bit checks on urx_top.
 * assumes a bind to urx_top; sees only its ports.
 */
`timescale 1ns/1ps
module urx_props
	import urx_pkg::*;
(
	input wire logic core_clk_in, // clock
	input wire logic rst_n_in, // reset, low
	input wire logic [6:0] avs_address_in, // address
	input wire logic avs_read_in, // read
	input wire logic avs_write_in, // write
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [31:0] avs_readdata_out, // read data
	input wire logic avs_waitrequest_out, // stall
	input wire logic rx_in, // serial in
	input wire logic [7:0] tx_data_out, // tx char
	input wire logic tx_push_out, // tx push
	input wire logic irq_out // interrupt
);
	// ************************************************************
	// helper logic
	// ************************************************************
	logic req; // any request up
	logic rd_done; // read answered now
	logic push_cause; // data-port write completes
	logic [10:0] mask_q; // shadow of the mask
	assign req = avs_read_in | avs_write_in;
	assign rd_done = avs_read_in & ~avs_waitrequest_out;
	assign push_cause = avs_write_in & ~avs_waitrequest_out & (avs_address_in == OFF_DATA);
	// shadow mask, so irq can be tied to it without seeing inside
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mask_q <= 11'h000;
		end
		else if (avs_write_in && !avs_waitrequest_out && avs_address_in == OFF_IMSK)
		begin
			mask_q <= avs_writedata_in[10:0];
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_ONE_WAIT: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("access not answered after one wait state");
	AST_FIRST_WAIT: assert property (req && !$past(req) |-> avs_waitrequest_out)
		else $error("first cycle of access not stalled");
	AST_UNMAPPED: assert property (rd_done && avs_address_in == 7'h08 |-> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	AST_TX_PUSH: assert property (push_cause |=> tx_push_out && tx_data_out == $past(avs_writedata_in[7:0]))
		else $error("data write did not push its character");
	AST_PUSH_CAUSE: assert property (tx_push_out |-> $past(push_cause))
		else $error("push without data write");
	AST_IRQ_MASK: assert property (mask_q[10:6] == 5'h00 |-> !irq_out)
		else $error("interrupt with all sources masked");
	AST_MSKD_SUBSET: assert property (rd_done && avs_address_in == OFF_MSKD |->
		(avs_readdata_out[10:0] & ~mask_q) == 11'h000 && avs_readdata_out[31:11] == 21'h0)
		else $error("masked status outside mask");
	AST_ICLR_ZERO: assert property (rd_done && avs_address_in == OFF_ICLR |-> avs_readdata_out == 32'h0)
		else $error("write-only register read back");
	AST_DATA_RSVD: assert property (rd_done && avs_address_in == OFF_DATA |-> avs_readdata_out[31:12] == 20'h0)
		else $error("data reserved bits set");
	AST_ERR_RSVD: assert property (rd_done && avs_address_in == OFF_ERR |-> avs_readdata_out[31:4] == 28'h0)
		else $error("error status reserved bits set");
	AST_IDLE_RSVD: assert property (rd_done && avs_address_in == OFF_IDLE |-> avs_readdata_out[31:22] == 10'h0)
		else $error("idle period above bit 21");
	// main scenarios reached
	COV_PUSH: cover property (push_cause);
	COV_IRQ: cover property (irq_out);
	COV_FLAGGED: cover property (rd_done && avs_address_in == OFF_DATA && avs_readdata_out[11:8] != 4'h0);
endmodule

// file: verification/urx_line_model.sv
/*
 * urx_line_model: remote serial transmitter driving the receive line.
 * assumes divisor 1, so one bit is sixteen core clocks; line idles high.
 */
`timescale 1ns/1ps
module urx_line_model
(
	input wire logic clk_in, // core clock
	output logic line_out // serial line
);
	localparam int BIT_CYC = 16; // clocks per bit
	initial line_out = 1'b1;
	// hold a level for n clocks, changed just after an edge
	task automatic hold(input logic v, input int n);
		line_out <= v;
		repeat (n) @(posedge clk_in);
	endtask
	// one 8-bit frame, lsb first; bad parity or stop only when asked
	task automatic send(input logic [7:0] c, input logic pen, input logic bad_par, input logic bad_stop);
		logic p;
		p = (^c) ^ bad_par;
		hold(1'b0, BIT_CYC);
		for (int i = 0; i < 8; i++)
		begin
			hold(c[i], BIT_CYC);
		end
		if (pen)
		begin
			hold(p, BIT_CYC);
		end
		hold(~bad_stop, BIT_CYC);
		hold(1'b1, BIT_CYC);
	endtask
endmodule

// file: verification/urx_top_tb.sv
/*
 * urx_top_tb: self-checking bench for urx_top with a serial line model.
 * assumes one wait state per access and divisor 1 (sixteen clocks a bit).
 */
`timescale 1ns/1ps
module urx_top_tb
	import urx_pkg::*;
;
	logic core_clk; // 250 MHz
	logic rst_n; // reset, low
	logic [6:0] addr; // bus address
	logic rd; // read request
	logic wr; // write request
	logic [31:0] wdata; // write data
	logic [31:0] rdata; // read data
	logic waitreq; // stall
	logic rx_line; // serial line
	logic [7:0] tx_data; // pushed char
	logic tx_push; // push pulse
	logic irq; // interrupt
	int num_errors; // mismatches
	int num_checks; // comparisons
	logic [31:0] q; // last read
	logic [31:0] d; // scratch data
	logic [7:0] c; // char under test
	logic [7:0] g; // following good char
	logic [7:0] sent[$]; // chars in flight
	logic [6:0] ra[6] = '{OFF_IDLE, OFF_CTRL, OFF_FIFO_LEVEL_SELECT, OFF_FLAG, OFF_RAW, OFF_IMSK};
	logic [31:0] rv[6] = '{32'h000001FF, 32'h00040300, 32'h00000012, 32'h00001E90, 32'h0, 32'h0};
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	urx_top uut (.core_clk_in(core_clk), .rst_n_in(rst_n), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .rx_in(rx_line),
		.tx_data_out(tx_data), .tx_push_out(tx_push), .irq_out(irq));
	urx_line_model line (.clk_in(core_clk), .line_out(rx_line));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// hold the request until waitrequest is seen low, then release
	task automatic xfer(input logic we, input logic [6:0] a, input logic [31:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr <= we;
		rd <= ~we;
		@(posedge core_clk);
		// no local limit: only the watchdog may end a hung access
		while (waitreq !== 1'b0)
		begin
			@(posedge core_clk);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		xfer(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	function automatic logic [31:0] exp_rx(input logic [7:0] ch, input logic [3:0] f);
		return {20'h00000, f, ch};
	endfunction
	// ************************************************************
	// watchdog: the full run needs about 9300 clocks
	// ************************************************************
	initial
	begin
		repeat (40000) @(posedge core_clk);
		num_errors++;
		close_out();
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		rd = 1'b0;
		wr = 1'b0;
		addr = 7'h00;
		wdata = 32'h0;
		rst_n = 1'b0;
		num_errors = 0;
		num_checks = 0;
		q = $urandom(32'hCAE2);
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			rd_chk(ra[i], rv[i]);
		end
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom & 32'hFF;
			xfer(1'b1, 7'(OFF_RES1 + 4 * i), d);
			rd_chk(7'(OFF_RES1 + 4 * i), d);
		end
		d = $urandom;
		xfer(1'b1, OFF_IDLE, d);
		rd_chk(OFF_IDLE, d & 32'h003FFFFF);
		xfer(1'b1, 7'h08, d);
		rd_chk(7'h08, 32'h0);
		rd_chk(OFF_ICLR, 32'h0);
		xfer(1'b1, OFF_DATA, d);
		// push pulse stands for the one cycle after the completing edge
		@(negedge core_clk);
		chk({23'h0, tx_push, tx_data}, {23'h0, 1'b1, d[7:0]});
		// run: divisor 1, 8 bits, fifo on, period 300 ticks, all rx sources unmasked
		xfer(1'b1, OFF_BAUD_DIVISOR_INTEGER, 32'h1);
		xfer(1'b1, OFF_RXLC, 32'h70);
		xfer(1'b1, OFF_IMSK, 32'h7C0);
		xfer(1'b1, OFF_IDLE, 32'h0000012C);
		xfer(1'b1, OFF_CTRL, 32'h00040301);
		// stale data with false starts in between; a glitch must not restart the count
		for (int i = 0; i < 3; i++)
		begin
			c = $urandom;
			sent.push_back(c);
			line.send(c, 1'b0, 1'b0, 1'b0);
		end
		rd_chk(OFF_RAW, 32'h0);
		repeat (20)
		begin
			line.hold(1'b0, 4);
			line.hold(1'b1, 12);
		end
		rd_chk(OFF_RAW, 32'h40);
		chk({31'h0, irq}, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			rd_chk(OFF_DATA, exp_rx(sent.pop_front(), 4'h0));
		end
		rd_chk(OFF_RAW, 32'h0);
		// timeout cleared by the clear register while data remains
		c = $urandom;
		line.send(c, 1'b0, 1'b0, 1'b0);
		repeat (320) @(posedge core_clk);
		rd_chk(OFF_RAW, 32'h40);
		xfer(1'b1, OFF_ICLR, 32'h40);
		rd_chk(OFF_RAW, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd_chk(OFF_DATA, exp_rx(c, 4'h0));
		// framing, parity, break, each followed by a good char
		xfer(1'b1, OFF_RXLC, 32'h76);
		for (int m = 0; m < 3; m++)
		begin
			// a zero char with a bad stop bit would look like a break
			c = (m == 2) ? 8'h00 : (8'($urandom) | 8'h01);
			g = $urandom;
			if (m == 2)
			begin
				line.hold(1'b0, 400);
				line.hold(1'b1, 32);
			end
			else
				line.send(c, 1'b1, m == 1, m == 0);
			line.send(g, 1'b1, 1'b0, 1'b0);
			rd_chk(OFF_RAW, 32'h80 << m, 32'h780);
			rd_chk(OFF_MSKD, 32'h80 << m, 32'h780);
			rd_chk(OFF_DATA, exp_rx(c, 4'h1 << m));
			rd_chk(OFF_ERR, 32'h1 << m);
			rd_chk(OFF_DATA, exp_rx(g, 4'h0));
			rd_chk(OFF_FLAG, 32'h10, 32'h50);
			xfer(1'b1, OFF_ICLR, 32'h80 << m);
			rd_chk(OFF_RAW, 32'h0, 32'h780);
		end
		// overrun: one char beyond a full fifo
		xfer(1'b1, OFF_RXLC, 32'h70);
		for (int i = 0; i < 33; i++)
		begin
			c = $urandom;
			sent.push_back(c);
			line.send(c, 1'b0, 1'b0, 1'b0);
		end
		rd_chk(OFF_RAW, 32'h400, 32'h400);
		rd_chk(OFF_ERR, 32'h8, 32'h8);
		for (int i = 0; i < 32; i++)
		begin
			rd_chk(OFF_DATA, {24'h0, sent[i]}, 32'hFF);
		end
		rd_chk(OFF_FLAG, 32'h10, 32'h50);
		// fifo off: depth one, so a second char overruns the holding word
		xfer(1'b1, OFF_ICLR, 32'h7C0);
		xfer(1'b1, OFF_RXLC, 32'h60);
		c = $urandom;
		g = $urandom;
		line.send(c, 1'b0, 1'b0, 1'b0);
		line.send(g, 1'b0, 1'b0, 1'b0);
		rd_chk(OFF_RAW, 32'h400, 32'h780);
		rd_chk(OFF_DATA, exp_rx(c, 4'h8));
		xfer(1'b1, OFF_ERR, $urandom);
		rd_chk(OFF_ERR, 32'h0);
		close_out();
	end
endmodule
bind urx_top urx_props u_props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .rx_in(rx_in), .tx_data_out(tx_data_out),
	.tx_push_out(tx_push_out), .irq_out(irq_out));
